// ---- rtcs_params.svh ----
`ifndef RTCS_PARAMS_SVH
`define RTCS_PARAMS_SVH

// Timing
`define RTCS_CLK_HZ          50000000
`define RTCS_RST_HOLD_MS     250
`define RTCS_RST_HOLD_CYC    (`RTCS_RST_HOLD_MS * (`RTCS_CLK_HZ / 1000))
`define RTCS_NV_WRITE_MS     5
`define RTCS_NV_WRITE_CYC    (`RTCS_NV_WRITE_MS * (`RTCS_CLK_HZ / 1000))

// Slave byte decode
`define RTCS_ID_ARRAY        4'ha
`define RTCS_ID_CCS          4'hd
`define RTCS_DEV_SEL         3'h7

// Bit counting within one byte plus acknowledge
`define RTCS_BIT_FIRST       4'h1
`define RTCS_BIT_LAST        4'h8
`define RTCS_BIT_ACK         4'h9

// Store layout: array 512 bytes, clock/control space 64 bytes above it
`define RTCS_MEM_AW          10
`define RTCS_PAGE_AW         4
`define RTCS_CCS_BASE        4'h8
`define RTCS_ADDR_RESET      16'h0000

// Weekday alarm registers inside the clock/control space
`define RTCS_WDAY_ALARM0     6'h06
`define RTCS_WDAY_ALARM1     6'h0e

`endif

// ---- rtcs_pkg.sv ----
package rtcs_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SLAVE,
      ST_ADDR_HI,
      ST_ADDR_LO,
      ST_WDATA,
      ST_RDATA,
      ST_RACK
   } rtcs_state_e;

endpackage : rtcs_pkg

// ---- rtcs_mem.sv ----
`timescale 1ns/1ps

module rtcs_mem #(
   parameter int DW = 8,
   parameter int AW = 10
) (
   // Clock
   input  wire logic          sys_clk_i,
   // Write port
   input  wire logic          wr_en_i,
   input  wire logic [AW-1:0] wr_addr_i,
   input  wire logic [DW-1:0] wr_data_i,
   // Read port, data registered
   input  wire logic [AW-1:0] rd_addr_i,
   output logic      [DW-1:0] rd_data_o
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge sys_clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
   end

endmodule : rtcs_mem

// ---- rtcs_serial_port.sv ----
// Contract
// - Reset output low, released 250ms after recovery
// - Low supply reset aborts transfers, refuses commands
// - Nonvolatile write finishes unless in battery mode
// - Battery mode keeps reset low until mains
// - SDA changes only while SCL low
// - Ignore bus until a start is seen
// - Stop ends transaction, returns to standby
// - Transmitter releases SDA, receiver acks ninth clock
// - Ack slave byte only on identifier match
// - Ack every byte received during writes
// - Read: eight bits, release, continue on ack
// - Upper bits 1010 array, 1101 control, select 111
// - Lowest slave bit one means read
// - Two-byte word address, counter starts zero
// - Stop after write starts busy, inputs ignored
// - Protected writes acked, no write cycle
// - Single-byte weekday alarm write not committed
// - Page holds 16 array or 8 control bytes
// - Write address wraps within page
// - Early or mid-byte stop abandons the write
// - No slave ack while write cycle busy
`timescale 1ns/1ps
`include "rtcs_params.svh"

module rtcs_serial_port
   import rtcs_pkg::*;
#(
   parameter int unsigned RST_HOLD_CYC = `RTCS_RST_HOLD_CYC,
   parameter int unsigned NV_WRITE_CYC = `RTCS_NV_WRITE_CYC
) (
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic resetn_i,
   // Two-wire bus, open drain data
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      sda_o,
   output logic      sda_oe_o,
   // Supply monitor, power state and write protect
   input  wire logic supply_low_i,
   input  wire logic battery_mode_i,
   input  wire logic wr_protect_i,
   // Status
   output logic      reset_n_o,
   output logic      nv_busy_o
);

   // Store decode helpers
   function automatic logic [`RTCS_MEM_AW-1:0] rtcs_map(input logic ccs, input logic [15:0] a);
      rtcs_map = ccs ? {`RTCS_CCS_BASE, a[5:0]} : {1'b0, a[8:0]};
   endfunction : rtcs_map

   function automatic logic [15:0] rtcs_rd_inc(input logic ccs, input logic [15:0] a);
      rtcs_rd_inc = ccs ? {10'h000, a[5:0] + 6'h01} : {7'h00, a[8:0] + 9'h001};
   endfunction : rtcs_rd_inc

   function automatic logic [15:0] rtcs_wr_inc(input logic ccs, input logic [15:0] a);
      rtcs_wr_inc = ccs ? {a[15:3], a[2:0] + 3'h1} : {a[15:4], a[3:0] + 4'h1};
   endfunction : rtcs_wr_inc

   // Pin synchronisers; first stage feeds only the second
   logic scl_m, scl_s, scl_d;
   logic sda_m, sda_s, sda_d;
   logic low_m, low_s;
   logic bat_m, bat_s;
   logic prot_m, prot_s;

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         {scl_m, scl_s, scl_d} <= 3'h7;
         {sda_m, sda_s, sda_d} <= 3'h7;
         {low_m, low_s}        <= 2'h3;
         {bat_m, bat_s}        <= 2'h0;
         {prot_m, prot_s}      <= 2'h0;
      end else begin
         {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
         {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
         {low_m, low_s}        <= {supply_low_i, low_m};
         {bat_m, bat_s}        <= {battery_mode_i, bat_m};
         {prot_m, prot_s}      <= {wr_protect_i, prot_m};
      end
   end

   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

   // Reset output generator
   logic [31:0] rst_cnt;

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         reset_n_o <= 1'b0;
         rst_cnt   <= 32'h0;
      end else if (low_s) begin
         reset_n_o <= 1'b0;
         rst_cnt   <= 32'h0;
      end else if (!reset_n_o) begin
         if (bat_s) begin
            rst_cnt <= 32'h0;
         end else if (rst_cnt == 32'(RST_HOLD_CYC - 1)) begin
            reset_n_o <= 1'b1;
         end else begin
            rst_cnt <= rst_cnt + 32'h1;
         end
      end
   end

   wire low_hold = ~reset_n_o;

   // Protocol state
   rtcs_state_e state;
   logic [3:0]  bit_cnt;
   logic [7:0]  rx_sh;
   logic [7:0]  tx_sh;
   logic        sel_ccs;
   logic        rd_dir;
   logic        acked;
   logic        ack_seen;
   logic [15:0] addr;
   logic [15:0] last_addr;
   logic [4:0]  wr_count;
   logic [15:0] wr_mask;

   // Write cycle state
   logic [31:0] nv_cnt;
   logic        cm_run;
   logic [3:0]  cm_idx;
   logic [3:0]  cm_idx_d;
   logic        cm_v_d;
   logic        cm_ccs;
   logic [15:0] cm_page;

   // Store and page buffer
   logic [7:0]  mem_rd;
   logic [7:0]  buf_rd;

   wire id_hit = (rx_sh[7:4] == `RTCS_ID_ARRAY || rx_sh[7:4] == `RTCS_ID_CCS)
                 && rx_sh[3:1] == `RTCS_DEV_SEL;
   wire is_rx  = (state == ST_SLAVE) || (state == ST_ADDR_HI) ||
                 (state == ST_ADDR_LO) || (state == ST_WDATA);
   wire give_ack = (state == ST_SLAVE) ? id_hit : is_rx;
   wire byte_end = is_rx && scl_fall && (bit_cnt == `RTCS_BIT_LAST);
   wire ack_end  = is_rx && scl_fall && (bit_cnt == `RTCS_BIT_ACK);
   wire buf_we   = byte_end && (state == ST_WDATA);
   wire wday_hit = (last_addr[5:0] == `RTCS_WDAY_ALARM0) ||
                   (last_addr[5:0] == `RTCS_WDAY_ALARM1);
   wire wr_block = (~sel_ccs & prot_s) |
                   (sel_ccs & (wr_count == 5'h01) & wday_hit);
   wire wr_done  = stop_c && (state == ST_WDATA) && (bit_cnt == `RTCS_BIT_FIRST) &&
                   (wr_count != 5'h00);
   wire wr_ok    = wr_done && !wr_block && !nv_busy_o && !low_hold;
   wire ignore   = low_hold | nv_busy_o;
   wire mem_we   = cm_v_d;
   wire [15:0] cm_addr = {cm_page[15:4], cm_idx_d};

   // Serial engine
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         state     <= ST_IDLE;
         bit_cnt   <= 4'h0;
         rx_sh     <= 8'h00;
         tx_sh     <= 8'h00;
         sel_ccs   <= 1'b0;
         rd_dir    <= 1'b0;
         acked     <= 1'b0;
         ack_seen  <= 1'b0;
         addr      <= `RTCS_ADDR_RESET;
         last_addr <= `RTCS_ADDR_RESET;
         wr_count  <= 5'h00;
         wr_mask   <= 16'h0000;
         sda_oe_o  <= 1'b0;
      end else if (ignore) begin
         state    <= ST_IDLE;
         sda_oe_o <= 1'b0;
      end else if (start_c) begin
         state    <= ST_SLAVE;
         bit_cnt  <= 4'h0;
         sda_oe_o <= 1'b0;
      end else if (stop_c) begin
         state    <= ST_IDLE;
         sda_oe_o <= 1'b0;
      end else begin
         if (is_rx && scl_rise && bit_cnt < `RTCS_BIT_LAST) begin
            rx_sh   <= {rx_sh[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
         end
         if (byte_end) begin
            sda_oe_o <= give_ack;
            acked    <= give_ack;
            bit_cnt  <= `RTCS_BIT_ACK;
            case (state)
               ST_SLAVE: begin
                  sel_ccs <= (rx_sh[7:4] == `RTCS_ID_CCS);
                  rd_dir  <= rx_sh[0];
                  if (id_hit && !rx_sh[0]) begin
                     wr_count <= 5'h00;
                     wr_mask  <= 16'h0000;
                  end
               end
               ST_ADDR_HI: addr[15:8] <= rx_sh;
               ST_ADDR_LO: addr[7:0]  <= rx_sh;
               ST_WDATA: begin
                  last_addr <= addr;
                  addr      <= rtcs_wr_inc(sel_ccs, addr);
                  wr_mask[addr[3:0]] <= 1'b1;
                  if (wr_count != 5'h1f) begin
                     wr_count <= wr_count + 5'h01;
                  end
               end
               default: ;
            endcase
         end
         if (ack_end) begin
            sda_oe_o <= 1'b0;
            bit_cnt  <= 4'h0;
            case (state)
               ST_SLAVE: begin
                  if (!acked) begin
                     state <= ST_IDLE;
                  end else if (rd_dir) begin
                     state    <= ST_RDATA;
                     tx_sh    <= mem_rd;
                     sda_oe_o <= ~mem_rd[7];
                     bit_cnt  <= `RTCS_BIT_FIRST;
                     addr     <= rtcs_rd_inc(sel_ccs, addr);
                  end else begin
                     state <= ST_ADDR_HI;
                  end
               end
               ST_ADDR_HI: state <= ST_ADDR_LO;
               ST_ADDR_LO: state <= ST_WDATA;
               default:    state <= state;
            endcase
         end
         if (state == ST_RDATA && scl_fall) begin
            if (bit_cnt == `RTCS_BIT_LAST) begin
               sda_oe_o <= 1'b0;
               state    <= ST_RACK;
               bit_cnt  <= 4'h0;
            end else begin
               sda_oe_o <= ~tx_sh[6];
               tx_sh    <= {tx_sh[6:0], 1'b0};
               bit_cnt  <= bit_cnt + 4'h1;
            end
         end
         if (state == ST_RACK && scl_rise) begin
            ack_seen <= ~sda_s;
         end
         if (state == ST_RACK && scl_fall) begin
            if (ack_seen) begin
               state    <= ST_RDATA;
               tx_sh    <= mem_rd;
               sda_oe_o <= ~mem_rd[7];
               bit_cnt  <= `RTCS_BIT_FIRST;
               addr     <= rtcs_rd_inc(sel_ccs, addr);
            end else begin
               state <= ST_IDLE;
            end
         end
      end
   end

   assign sda_o = 1'b0;

   // Write cycle: busy timer and page commit from the buffer
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         nv_cnt    <= 32'h0;
         nv_busy_o <= 1'b0;
         cm_run    <= 1'b0;
         cm_idx    <= 4'h0;
         cm_idx_d  <= 4'h0;
         cm_v_d    <= 1'b0;
         cm_ccs    <= 1'b0;
         cm_page   <= 16'h0000;
      end else if (low_hold && bat_s) begin
         nv_cnt    <= 32'h0;
         nv_busy_o <= 1'b0;
         cm_run    <= 1'b0;
         cm_v_d    <= 1'b0;
      end else if (wr_ok) begin
         nv_cnt    <= 32'(NV_WRITE_CYC);
         nv_busy_o <= 1'b1;
         cm_run    <= 1'b1;
         cm_idx    <= 4'h0;
         cm_v_d    <= 1'b0;
         cm_ccs    <= sel_ccs;
         cm_page   <= addr;
      end else begin
         if (nv_busy_o) begin
            nv_cnt <= nv_cnt - 32'h1;
            if (nv_cnt == 32'h1) begin
               nv_busy_o <= 1'b0;
            end
         end
         cm_idx_d <= cm_idx;
         cm_v_d   <= cm_run & wr_mask[cm_idx];
         if (cm_run) begin
            cm_idx <= cm_idx + 4'h1;
            if (cm_idx == 4'hf) begin
               cm_run <= 1'b0;
            end
         end
      end
   end

   // Page buffer holds data until a clean stop, so abandoned writes leave the store intact
   rtcs_mem #(
      .DW (8),
      .AW (`RTCS_PAGE_AW)
   ) u_page_buf (
      .sys_clk_i (sys_clk_i),
      .wr_en_i   (buf_we),
      .wr_addr_i (addr[3:0]),
      .wr_data_i (rx_sh),
      .rd_addr_i (cm_idx),
      .rd_data_o (buf_rd)
   );

   rtcs_mem #(
      .DW (8),
      .AW (`RTCS_MEM_AW)
   ) u_store (
      .sys_clk_i (sys_clk_i),
      .wr_en_i   (mem_we),
      .wr_addr_i (rtcs_map(cm_ccs, cm_addr)),
      .wr_data_i (buf_rd),
      .rd_addr_i (rtcs_map(sel_ccs, addr)),
      .rd_data_o (mem_rd)
   );

   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_clean_stop;
      wr_done && !wr_block && !ignore;
   endsequence

   sequence s_slave_miss;
      state == ST_SLAVE && byte_end && !id_hit;
   endsequence

   AST_RST_LOW: assert property (low_s |=> !reset_n_o)
      else $error("reset output not low under low supply");
   AST_RST_BATT: assert property (!reset_n_o && bat_s |=> !reset_n_o)
      else $error("reset released while in battery mode");
   AST_LOW_ABORT: assert property (low_hold |=> state == ST_IDLE && !sda_oe_o)
      else $error("transfer continued during low supply reset");
   AST_SDA_EDGE: assert property ($changed(sda_oe_o) |-> $past(scl_fall) || !scl_s)
      else $error("SDA driven change while SCL high");
   AST_NACK_MISS: assert property (s_slave_miss |=> !sda_oe_o ##1 !sda_oe_o)
      else $error("slave byte mismatch acknowledged");
   AST_WR_ACK: assert property (byte_end && state != ST_SLAVE && !ignore && !start_c
                               && !stop_c |=> sda_oe_o)
      else $error("received write byte not acknowledged");
   AST_RD_RELEASE: assert property (state == ST_RACK |-> !sda_oe_o)
      else $error("SDA held during read acknowledge clock");
   AST_NV_START: assert property (s_clean_stop |=> nv_busy_o ##1 nv_busy_o)
      else $error("write cycle not started after valid stop");
   AST_BUSY_QUIET: assert property (nv_busy_o |=> !sda_oe_o && state == ST_IDLE)
      else $error("bus answered during write cycle");
   AST_ABANDON: assert property (stop_c && state == ST_WDATA && bit_cnt != `RTCS_BIT_FIRST
                                && !nv_busy_o |=> !nv_busy_o)
      else $error("mid-byte stop started a write cycle");
   AST_PROT: assert property (wr_done && !sel_ccs && prot_s && !nv_busy_o
                             |=> !nv_busy_o)
      else $error("protected write started a write cycle");

endmodule : rtcs_serial_port

// ---- rtcs_master_model.sv ----
`timescale 1ns/1ps

module rtcs_master_model (
   // Clock
   input  wire logic       sys_clk_i,
   // Bus side, SDA pulled up outside
   output logic            scl_o,
   output logic            sda_pull_o,
   input  wire logic       sda_i,
   // Results to the bench
   output logic            res_stb_o,
   output logic [7:0]      res_o
);
   initial begin
      scl_o      = 1'b1;
      sda_pull_o = 1'b0;
      res_stb_o  = 1'b0;
      res_o      = 8'h00;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask : wt

   // SDA moves mid low phase so it never races the SCL rise
   task automatic clk_bit(input logic b, output logic s);
      wt(2);
      sda_pull_o <= ~b;
      wt(2);
      scl_o <= 1'b1;
      wt(4);
      s = sda_i;
      scl_o <= 1'b0;
   endtask : clk_bit

   task automatic post(input logic [7:0] v);
      res_o <= v;
      res_stb_o <= 1'b1;
      wt(1);
      res_stb_o <= 1'b0;
   endtask : post

   // SCL stands high between frames
   task automatic start();
      if (!scl_o) begin
         wt(2);
         sda_pull_o <= 1'b0;
         wt(2);
         scl_o <= 1'b1;
         wt(4);
      end
      sda_pull_o <= 1'b1;
      wt(4);
      scl_o <= 1'b0;
   endtask : start

   task automatic stop();
      wt(2);
      sda_pull_o <= 1'b1;
      wt(2);
      scl_o <= 1'b1;
      wt(4);
      sda_pull_o <= 1'b0;
      wt(4);
   endtask : stop

   // Fewer than 8 bits leaves the byte cut short, no ack clock
   task automatic send(input logic [7:0] d, input int nbits);
      logic s;
      for (int i = 7; i >= 8 - nbits; i--) clk_bit(d[i], s);
      if (nbits == 8) begin
         clk_bit(1'b1, s);
         post({7'h00, s});
      end
   endtask : send

   task automatic recv(input logic ack);
      logic [7:0] d;
      logic       s;
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
      clk_bit(~ack, s);
      post(d);
   endtask : recv
endmodule : rtcs_master_model

// ---- rtc_eeprom_serial_slave_port_bench.sv ----
`timescale 1ns/1ps

module rtc_eeprom_serial_slave_port_bench;
   localparam int RST = 50;
   localparam int NV  = 200;
   // Status register offset in the control space is a free choice here
   localparam logic [15:0] STAT = 16'h003f;
   logic       sys_clk, resetn, supply_low, battery_mode, wr_protect;
   logic       sda_o, sda_oe, reset_n, nv_busy, scl, m_pull, res_stb;
   logic [7:0] res;
   wire        sda = (m_pull || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
   logic [7:0] mem [0:575];
   logic [7:0] exp_q [$];
   logic [7:0] slv [8] = '{8'hae, 8'hde, 8'hac, 8'hda, 8'hbe, 8'h5e, 8'hce, 8'h2e};
   int         n_fail = 0, checks = 0, busy_cnt = 0, busy_len = 0;
   logic [15:0] a;

   rtcs_serial_port #(.RST_HOLD_CYC(RST), .NV_WRITE_CYC(NV)) u_dut (
      .sys_clk_i(sys_clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe_o(sda_oe), .supply_low_i(supply_low), .battery_mode_i(battery_mode),
      .wr_protect_i(wr_protect), .reset_n_o(reset_n), .nv_busy_o(nv_busy));
   rtcs_master_model u_m (.sys_clk_i(sys_clk), .scl_o(scl), .sda_pull_o(m_pull),
      .sda_i(sda), .res_stb_o(res_stb), .res_o(res));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic end_sim();
      if (exp_q.size() != 0) n_fail++;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_sim

   // Oldest noted result against each result the master reports
   always @(posedge sys_clk) begin
      if (res_stb === 1'b1) begin
         if (exp_q.size() == 0) chk(res, 8'hxx);
         else chk(res, exp_q.pop_front());
      end
      if (nv_busy === 1'b1) busy_cnt <= busy_cnt + 1;
      else begin
         if (busy_cnt != 0) busy_len <= busy_cnt;
         busy_cnt <= 0;
      end
   end

   function automatic logic [7:0] sb(input logic ctl, input logic rd);
      return {ctl ? 4'hd : 4'ha, 3'h7, rd};
   endfunction : sb

   function automatic int idx(input logic ctl, input logic [15:0] p);
      return ctl ? 512 + int'(p[5:0]) : int'(p[8:0]);
   endfunction : idx

   task automatic snd(input logic [7:0] b, input logic ack);
      exp_q.push_back({7'h00, ~ack});
      u_m.send(b, 8);
   endtask : snd

   task automatic poll(input logic ack);
      u_m.start();
      snd(sb(1'b0, 1'b0), ack);
      u_m.stop();
   endtask : poll

   task automatic wr(input logic ctl, input logic [15:0] a0, input int n, input logic commit);
      logic [15:0] p;
      logic [7:0]  d;
      p = a0;
      u_m.start();
      snd(sb(ctl, 1'b0), 1'b1);
      snd(a0[15:8], 1'b1);
      snd(a0[7:0], 1'b1);
      for (int k = 0; k < n; k++) begin
         d = 8'($urandom);
         snd(d, 1'b1);
         if (commit) mem[idx(ctl, p)] = d;
         p = ctl ? {p[15:3], p[2:0] + 3'h1} : {p[15:4], p[3:0] + 4'h1};
      end
      u_m.stop();
   endtask : wr

   // Two separate writes of the unlock values precede any control space write
   task automatic unlock(input logic [7:0] v);
      u_m.start();
      snd(sb(1'b1, 1'b0), 1'b1);
      snd(STAT[15:8], 1'b1);
      snd(STAT[7:0], 1'b1);
      snd(v, 1'b1);
      u_m.stop();
      mem[idx(1'b1, STAT)] = v;
      wait_idle();
   endtask : unlock

   task automatic rd(input logic ctl, input logic [15:0] a0, input int n, input logic seta);
      logic [15:0] p;
      p = a0;
      if (seta) begin
         u_m.start();
         snd(sb(ctl, 1'b0), 1'b1);
         snd(a0[15:8], 1'b1);
         snd(a0[7:0], 1'b1);
      end
      u_m.start();
      snd(sb(ctl, 1'b1), 1'b1);
      for (int k = 0; k < n; k++) begin
         exp_q.push_back(mem[idx(ctl, p)]);
         u_m.recv(k != n - 1);
         p = ctl ? {p[15:6], p[5:0] + 6'h01} : {p[15:9], p[8:0] + 9'h001};
      end
      u_m.stop();
   endtask : rd

   task automatic wait_idle();
      for (int k = 0; k < NV + 50 && nv_busy !== 1'b0; k++) @(posedge sys_clk);
      repeat (3) @(posedge sys_clk);
      chk({7'h00, busy_len >= NV && busy_len <= NV + 1}, 8'h01);
   endtask : wait_idle

   task automatic no_busy();
      int h;
      h = 0;
      repeat (30) begin
         @(posedge sys_clk);
         if (nv_busy !== 1'b0) h++;
      end
      chk(8'(h), 8'h00);
   endtask : no_busy

   task automatic rst_rel(input logic exp_late);
      repeat (RST - 2) @(posedge sys_clk);
      chk({7'h00, reset_n}, 8'h00);
      repeat (10) @(posedge sys_clk);
      chk({7'h00, reset_n}, {7'h00, exp_late});
   endtask : rst_rel

   initial begin
      #1_000_000;
      n_fail++;
      end_sim();
   end

   initial begin
      resetn = 1'b0;
      supply_low = 1'b0;
      battery_mode = 1'b0;
      wr_protect = 1'b0;
      a = 16'($urandom(32'hfb33c41c));
      repeat (10) @(posedge sys_clk);
      chk({6'h00, reset_n, nv_busy}, 8'h00);
      resetn <= 1'b1;
      rst_rel(1'b1);
      foreach (slv[i]) begin
         u_m.start();
         snd(slv[i], (slv[i][7:4] == 4'ha || slv[i][7:4] == 4'hd) && slv[i][3:1] == 3'h7);
         u_m.stop();
      end
      a = 16'($urandom) & 16'h01ff;
      wr(1'b0, a, 1, 1'b1);
      poll(1'b0);
      wait_idle();
      poll(1'b1);
      rd(1'b0, a, 1, 1'b1);
      wr(1'b0, 16'h000e, 18, 1'b1);
      wait_idle();
      rd(1'b0, 16'h0000, 16, 1'b1);
      unlock(8'h02);
      unlock(8'h06);
      rd(1'b1, STAT, 1, 1'b1);
      wr(1'b1, 16'h0006, 1, 1'b0);
      no_busy();
      wr(1'b1, 16'h0008, 9, 1'b1);
      wait_idle();
      rd(1'b1, 16'h0008, 8, 1'b1);
      wr_protect <= 1'b1;
      wr(1'b0, 16'h0003, 2, 1'b0);
      no_busy();
      poll(1'b1);
      wr_protect <= 1'b0;
      rd(1'b0, 16'h0002, 3, 1'b1);
      u_m.start();
      snd(sb(1'b0, 1'b0), 1'b1);
      snd(8'h00, 1'b1);
      snd(8'h05, 1'b1);
      u_m.send(8'h5a, 4);
      u_m.stop();
      no_busy();
      rd(1'b0, 16'h0005, 1, 1'b1);
      resetn <= 1'b0;
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      rst_rel(1'b1);
      rd(1'b0, 16'h0000, 2, 1'b0);
      wr(1'b0, 16'h0100, 1, 1'b1);
      repeat (5) @(posedge sys_clk);
      supply_low <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk({7'h00, reset_n}, 8'h00);
      wait_idle();
      poll(1'b0);
      supply_low <= 1'b0;
      rst_rel(1'b1);
      rd(1'b0, 16'h0100, 1, 1'b1);
      battery_mode <= 1'b1;
      supply_low <= 1'b1;
      repeat (6) @(posedge sys_clk);
      supply_low <= 1'b0;
      repeat (RST + 10) @(posedge sys_clk);
      chk({7'h00, reset_n}, 8'h00);
      battery_mode <= 1'b0;
      rst_rel(1'b1);
      end_sim();
   end
endmodule : rtc_eeprom_serial_slave_port_bench
